// *** rtl/dcf_channel_fifo_ctrl.v ***
`timescale 1ns/1ps
`include "dcf_defs.vh"
// ----------------------------------------------------------------
// Per-channel sample FIFO control, status and interrupt flags
// ----------------------------------------------------------------
module dcf_channel_fifo_ctrl #(
  parameter NCH = 32  // Number of channel FIFOs
) (
  input  wire                          clk_sys,            // System clock, 20 MHz
  input  wire                          rstn,               // Async reset, active low
  // Register port
  input  wire [`DCF_ADDR_W-1:0]        regAddr,            // Byte address
  input  wire                          regWrEn,            // Write strobe
  input  wire [31:0]                   regWrData,          // Write data
  input  wire                          regRdEn,            // Read strobe
  output reg  [31:0]                   regRdData,          // Read data, next cycle
  output reg                           regRdValid,         // Read data valid pulse
  // Region bounds from the address registers
  input  wire [NCH*`DCF_PTR_W-1:0]     regionStartAddress, // Per-channel start
  input  wire [NCH*`DCF_PTR_W-1:0]     regionEndAddress,   // Per-channel end
  // Host sample write space
  input  wire                          hostWrValid,        // Host offers a sample
  output wire                          hostWrReady,        // Buffer has room
  input  wire [`DCF_CHAN_W-1:0]        hostWrChan,         // Target channel
  input  wire [`DCF_SAMPLE_W-1:0]      hostWrData,         // Sample value
  // Board memory write side
  output reg                           sramWrEn,           // Memory write pulse
  output reg  [`DCF_PTR_W-1:0]         sramWrAddr,         // Memory address
  output reg  [`DCF_SAMPLE_W-1:0]      sramWrData,         // Memory data
  input  wire                          sramWrReady,        // Memory can take a write
  // Sequencer read side
  input  wire                          seqRdReq,           // Sequencer wants a sample
  input  wire [`DCF_CHAN_W-1:0]        seqRdChan,          // Requested channel
  output wire                          seqRdGrant,         // Request taken
  output reg                           seqRdAddrValid,     // Address valid pulse
  output reg  [`DCF_PTR_W-1:0]         seqRdAddr,          // Memory read address
  // Interrupt outputs
  input  wire                          masterIrqEnable,    // Global interrupt enable
  output reg                           fifoIrqPending,     // Any flag set
  output reg                           hostIrq             // Host interrupt line
);

  localparam PW = `DCF_PTR_W;
  localparam SW = `DCF_SAMPLE_W;
  localparam CW = `DCF_CHAN_W;

  // ----------------------------------------------------------------
  // Operating notes
  // ----------------------------------------------------------------
  // Pointers leave reset at zero, not at the region start,
  // so each channel wants one flush before its first sample.
  // Region bounds live outside this block; nothing here sees them
  // move, so the host flushes a channel after changing them.
  // Full is judged against the region size, so a channel holds
  // end minus start plus one samples and drops the rest.
  // Count moves only on accepted writes and consuming reads; a
  // replay with halt clear reads on past the fill level and
  // leaves the count at zero.
  // An exponent at or above the pointer width keeps low water set,
  // since no count can ever reach that threshold.
  // Interrupt flags need the per-FIFO enable and the FIFO enable
  // at the moment the condition arises; enabling later while the
  // channel already sits low raises nothing.
  // Flush wins over a write or read landing in the same cycle.

  // ----------------------------------------------------------------
  // Input buffer between host writes and memory
  // ----------------------------------------------------------------
  wire          drainValid;  // Buffered sample waiting
  wire [CW+SW-1:0] drainWord; // Channel and sample
  wire          drainFire;   // Sample leaves the buffer

  // Memory back-pressure stalls the buffer, which stalls the host
  // A sample for a full channel is still popped and dropped, so the
  // buffer never wedges behind a channel that nobody drains
  assign drainFire = drainValid && sramWrReady;

  dcf_stream_fifo #(
    .WIDTH (CW+SW),
    .DEPTH (`DCF_BUF_DEPTH),
    .AW    (4)
  ) uBuf (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .inValid  (hostWrValid),
    .inReady  (hostWrReady),
    .inData   ({hostWrChan, hostWrData}),
    .outValid (drainValid),
    .outReady (sramWrReady),
    .outData  (drainWord)
  );

  wire [CW-1:0] drainChan = drainWord[CW+SW-1:SW];  // Buffered channel
  wire [SW-1:0] drainData = drainWord[SW-1:0];      // Buffered sample

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire [`DCF_ADDR_W-1:0] ctrlOff = regAddr - `DCF_CTRL_BASE;  // Offset in block
  wire ctrlHit = (regAddr >= `DCF_CTRL_BASE) && (regAddr < `DCF_CTRL_END)
                 && (regAddr[1:0] == 2'h0);
  wire [CW-1:0] ctrlIdx = ctrlOff[CW+1:2];                    // Channel index

  reg  [NCH-1:0] irqEnable;  // Per-FIFO interrupt enable
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irqEnable <= `DCF_RST_IRQ_EN;
    end else if (regWrEn && regAddr == `DCF_IRQ_ENABLE) begin
      irqEnable <= regWrData[NCH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-channel state
  // ----------------------------------------------------------------
  wire [NCH*PW-1:0] wrPtrFlat;   // Write pointers
  wire [NCH*PW-1:0] rdPtrFlat;   // Read pointers
  wire [NCH*32-1:0] statusFlat;  // Status words
  wire [NCH-1:0]    rdOk;        // Channel may be read
  wire [NCH-1:0]    fullVec;     // Channel full
  wire [NCH-1:0]    irqFlag;     // Interrupt flags

  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : gCh
      reg  [PW-1:0] wrPtr;     // Next write address
      reg  [PW-1:0] rdPtr;     // Next read address
      reg  [PW-1:0] count;     // Unconverted samples
      reg           halt;      // Stop when empty
      reg           enable;    // FIFO enable
      reg  [4:0]    exponent;  // Low-water exponent
      reg           lowPrev;   // Low-water last cycle
      reg           emptyPrev; // Empty last cycle
      reg           flag;      // Interrupt flag

      wire [PW-1:0] startA = regionStartAddress[i*PW +: PW];
      wire [PW-1:0] endA   = regionEndAddress[i*PW +: PW];
      wire [PW:0]   capacity = {1'b0, endA} - {1'b0, startA} + 1'b1;
      // threshold is two to the exponent
      wire [31:0]   threshold = 32'h0000_0001 << exponent;
      // full when count reaches region size
      wire          full  = ({1'b0, count} >= capacity);
      wire          empty = (count == {PW{1'b0}});
      wire          low   = ({{(32-PW){1'b0}}, count} < threshold);
      wire          ctrlWr = regWrEn && ctrlHit && (ctrlIdx == i);
      // flush is a write pulse, never stored
      wire          flush = ctrlWr && regWrData[`DCF_BIT_FLUSH];
      wire          wrHit = drainFire && (drainChan == i);
      wire          accept = wrHit && !full;
      wire          rdHit = seqRdReq && (seqRdChan == i) && rdOk[i];
      // Count only drops while samples are unconverted
      wire          consume = rdHit && !empty;
      wire          trigger = ((low && !lowPrev) || (empty && !emptyPrev));

      // halt and empty blocks reads; disabled blocks reads
      assign rdOk[i]    = enable && !(halt && empty);
      assign fullVec[i] = full;
      assign irqFlag[i] = flag;
      assign wrPtrFlat[i*PW +: PW] = wrPtr;
      assign rdPtrFlat[i*PW +: PW] = rdPtr;
      // status word as read by software
      assign statusFlat[i*32 +: 32] = {halt, count, full, low, empty, enable,
                                       1'b0, exponent};

      // Control fields
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          halt     <= 1'b0;
          enable   <= 1'b0;
          exponent <= `DCF_RST_EXP;
        end else if (ctrlWr) begin
          halt     <= regWrData[`DCF_BIT_HALT];
          enable   <= regWrData[`DCF_BIT_ENABLE];
          exponent <= regWrData[`DCF_EXP_HI:`DCF_EXP_LO];
        end
      end

      // Pointers and count
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          wrPtr <= {PW{1'b0}};
          rdPtr <= {PW{1'b0}};
          count <= {PW{1'b0}};
        end else if (flush) begin
          wrPtr <= startA;
          rdPtr <= startA;
          count <= {PW{1'b0}};
        end else begin
          if (accept) begin
            wrPtr <= (wrPtr == endA) ? startA : wrPtr + 1'b1;
          end
          if (rdHit) begin
            rdPtr <= (rdPtr == endA) ? startA : rdPtr + 1'b1;
          end
          // count follows accepted writes and consuming reads
          if (accept && !consume) begin
            count <= count + 1'b1;
          end else if (consume && !accept) begin
            count <= count - 1'b1;
          end
        end
      end

      // Interrupt flag; reset history matches reset flags so no event
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          lowPrev   <= 1'b1;
          emptyPrev <= 1'b1;
          flag      <= 1'b0;
        end else begin
          lowPrev   <= low;
          emptyPrev <= empty;
          // enable must already be set; set wins over clear
          if (trigger && irqEnable[i] && enable) begin
            flag <= 1'b1;
          // refilled to the threshold clears it
          end else if (!low) begin
            flag <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Memory write and sequencer address outputs
  // ----------------------------------------------------------------
  assign seqRdGrant = seqRdReq && rdOk[seqRdChan];

  // Registered so memory sees clean address and data
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sramWrEn       <= 1'b0;
      sramWrAddr     <= {PW{1'b0}};
      sramWrData     <= {SW{1'b0}};
      seqRdAddrValid <= 1'b0;
      seqRdAddr      <= {PW{1'b0}};
    end else begin
      // Discarded samples produce no memory write
      sramWrEn <= drainFire && !fullVec[drainChan];
      if (drainFire) begin
        sramWrAddr <= wrPtrFlat[drainChan*PW +: PW];
        sramWrData <= drainData;
      end
      seqRdAddrValid <= seqRdGrant;
      if (seqRdGrant) begin
        seqRdAddr <= rdPtrFlat[seqRdChan*PW +: PW];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  // Registered so the host line never glitches on flag updates;
  // the price is one cycle of latency behind the flags
  // any flag drives status bit and gated host line
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fifoIrqPending <= 1'b0;
      hostIrq        <= 1'b0;
    end else begin
      fifoIrqPending <= |irqFlag;
      hostIrq        <= (|irqFlag) && masterIrqEnable;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Whole-word decode only: byte lanes are not supported, so any
  // access off a 32-bit word boundary matches no register
  reg [31:0] next_regRdData;  // Selected read word
  always @* begin
    next_regRdData = 32'h0000_0000;
    // Unmapped addresses read as zero
    if (ctrlHit) begin
      next_regRdData = statusFlat[ctrlIdx*32 +: 32];
    end else if (regAddr == `DCF_IRQ_FLAGS) begin
      next_regRdData[NCH-1:0] = irqFlag;
    end else if (regAddr == `DCF_IRQ_ENABLE) begin
      next_regRdData[NCH-1:0] = irqEnable;
    end
  end

  // Read data held until the next read
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regRdData  <= 32'h0000_0000;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= next_regRdData;
      end
    end
  end

endmodule

// *** rtl/dcf_stream_fifo.v ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Small synchronous FIFO with valid/ready on both sides
// ----------------------------------------------------------------
module dcf_stream_fifo #(
  parameter WIDTH = 21,  // Word width
  parameter DEPTH = 16,  // Number of entries, power of two
  parameter AW    = 4    // Log2 of depth
) (
  input  wire             clk_sys,  // System clock
  input  wire             rstn,     // Async reset, active low
  input  wire             inValid,  // Source offers a word
  output wire             inReady,  // Room for a word
  input  wire [WIDTH-1:0] inData,   // Incoming word
  output wire             outValid, // A word is waiting
  input  wire             outReady, // Drain takes the word
  output wire [WIDTH-1:0] outData   // Oldest word
);

  // Storage and pointers, one extra bit to tell full from empty
  reg [WIDTH-1:0] mem [0:DEPTH-1];  // Entry storage
  reg [AW:0]      wrPtr;            // Fill pointer
  reg [AW:0]      rdPtr;            // Drain pointer

  wire empty = (wrPtr == rdPtr);
  wire full  = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  wire push  = inValid && !full;
  wire pop   = outValid && outReady;

  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr[AW-1:0]];

  // Pointer update
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= {(AW+1){1'b0}};
      rdPtr <= {(AW+1){1'b0}};
    end else begin
      // Push when room
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      // Pop when drained
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

  // Entry write, no reset needed on data
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

endmodule

// *** shared/dcf_defs.vh ***
// Functional notes
// - Halt set and empty stops sequencer reads
// - Report unconverted sample count, resets zero
// - Full flag set, writes then discarded
// - Low-water flag when count below limit
// - Empty flag when no samples remain
// - Enable bit permits readout and interrupts
// - Flush returns both pointers to start
// - Threshold is two to the exponent
// - One interrupt flag per FIFO, bit order
// - Flag sets only if enable already set
// - Any flag raises status bit, host line
// - Flag clears itself once refilled to the limit
// - Write pointer wraps from end to start
// - Per-FIFO interrupt enable, resets to zero
`ifndef DCF_DEFS_VH
`define DCF_DEFS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define DCF_ADDR_W        12
`define DCF_CTRL_BASE     12'h198
`define DCF_CTRL_END      12'h218
`define DCF_IRQ_FLAGS     12'h218
`define DCF_IRQ_ENABLE    12'h21c

// ----------------------------------------------------------------
// Status/control field positions
// ----------------------------------------------------------------
`define DCF_BIT_HALT      31
`define DCF_CNT_HI        30
`define DCF_CNT_LO        10
`define DCF_BIT_FULL      9
`define DCF_BIT_LOW       8
`define DCF_BIT_EMPTY     7
`define DCF_BIT_ENABLE    6
`define DCF_BIT_FLUSH     5
`define DCF_EXP_HI        4
`define DCF_EXP_LO        0

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define DCF_RST_EXP       5'h00
`define DCF_RST_IRQ_EN    32'h0000_0000
`define DCF_PTR_W         21
`define DCF_SAMPLE_W      16
`define DCF_CHAN_W        5
`define DCF_BUF_DEPTH     16

`endif

// *** verif/dcf_ctrl_props.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for channel FIFO control
// ----------------------------------------------------------------
module dcf_ctrl_props (
  input wire clk_sys,         // Clock
  input wire rstn,            // Reset, active low
  input wire regRdEn,         // Read strobe
  input wire regRdValid,      // Read answer
  input wire hostWrReady,     // Buffer room
  input wire sramWrEn,        // Memory write
  input wire sramWrReady,     // Memory ready
  input wire seqRdReq,        // Sequencer request
  input wire seqRdGrant,      // Request taken
  input wire seqRdAddrValid,  // Address pulse
  input wire masterIrqEnable, // Global enable
  input wire fifoIrqPending,  // Any flag
  input wire hostIrq          // Host line
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Cause standing two cycles
  sequence irqHeld;
    (fifoIrqPending && masterIrqEnable) [*2];
  endsequence
  // No cause for two cycles
  sequence irqIdle;
    (!fifoIrqPending) [*2];
  endsequence
  reset_quiet_a: assert property (
    $rose(rstn) |-> !regRdValid && !sramWrEn && !seqRdAddrValid && !hostIrq && hostWrReady)
    else $error("outputs busy after reset");
  read_valid_a: assert property (
    regRdValid == $past(regRdEn)) else $error("read answer mistimed");
  grant_request_a: assert property (
    seqRdGrant |-> seqRdReq) else $error("grant without request");
  addr_pulse_a: assert property (
    seqRdAddrValid == $past(seqRdReq && seqRdGrant)) else $error("read address mistimed");
  mem_ready_a: assert property (
    sramWrEn |-> $past(sramWrReady)) else $error("memory write while stalled");
  irq_gate_a: assert property (
    hostIrq |-> $past(masterIrqEnable)) else $error("host line while disabled");
  irq_raise_a: assert property (
    irqHeld |-> hostIrq) else $error("host line missing");
  irq_quiet_a: assert property (
    irqIdle |-> !hostIrq) else $error("host line without flag");
endmodule
bind dcf_channel_fifo_ctrl dcf_ctrl_props dcf_ctrl_props_i (
  .clk_sys(clk_sys), .rstn(rstn), .regRdEn(regRdEn), .regRdValid(regRdValid),
  .hostWrReady(hostWrReady), .sramWrEn(sramWrEn), .sramWrReady(sramWrReady),
  .seqRdReq(seqRdReq), .seqRdGrant(seqRdGrant), .seqRdAddrValid(seqRdAddrValid),
  .masterIrqEnable(masterIrqEnable), .fifoIrqPending(fifoIrqPending), .hostIrq(hostIrq));

// *** verif/dcf_seq_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Sequencer stand-in pulling samples
// ----------------------------------------------------------------
module dcf_seq_model (
  input  wire        clk_sys,        // Clock
  input  wire        rstn,           // Reset, active low
  input  wire        run,            // Sequencer enabled
  input  wire        slow,           // Idle cycle between requests
  input  wire        seqRdGrant,     // Request taken
  input  wire        seqRdAddrValid, // Address pulse
  input  wire [20:0] seqRdAddr,      // Read address
  output reg         seqRdReq,       // Request line
  output wire [4:0]  seqRdChan,      // Channel asked for
  output reg  [20:0] lastAddr,       // Last address seen
  output reg  [15:0] nReads          // Reads completed
);
  assign seqRdChan = 5'h00;  // Only the first FIFO is exercised
  // Request held until granted; dropped when disabled, or for one cycle after a grant when slow
  // idle before flush, replay
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seqRdReq <= 1'b0;
      lastAddr <= 21'h000000;
      nReads   <= 16'h0000;
    end else begin
      if (seqRdAddrValid) begin
        nReads   <= nReads + 16'h0001;
        lastAddr <= seqRdAddr;
      end
      if (!run)
        seqRdReq <= 1'b0;
      else if (!seqRdReq || seqRdGrant)
        seqRdReq <= !(slow && seqRdReq);
    end
  end
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`include "dcf_defs.vh"
// ----------------------------------------------------------------
// Bench for channel FIFO control
// ----------------------------------------------------------------
module tb_top;
  reg         clk_sys, rstn, regWrEn, regRdEn, hostWrValid, sramWrReady;
  reg         masterIrqEnable, run, slow;
  reg  [11:0] regAddr;
  reg  [31:0] regWrData;
  reg  [15:0] hostWrData;
  reg  [20:0] lastWr;    // Last memory address written
  reg  [15:0] lastData;  // Last sample written
  wire [31:0] regRdData;
  wire        regRdValid, hostWrReady, sramWrEn, seqRdReq, seqRdGrant;
  wire        seqRdAddrValid, fifoIrqPending, hostIrq;
  wire [20:0] sramWrAddr, seqRdAddr, lastAddr;
  wire [4:0]  seqRdChan;
  wire [15:0] nReads, sramWrData;
  integer     nWr, n_errors, n_checks, cyc;
  dcf_channel_fifo_ctrl dcf_channel_fifo_ctrl_i (
    .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .regionStartAddress({32{21'h000010}}), .regionEndAddress({32{21'h000017}}),
    .hostWrValid(hostWrValid), .hostWrReady(hostWrReady), .hostWrChan(5'h00),
    .hostWrData(hostWrData), .sramWrEn(sramWrEn), .sramWrAddr(sramWrAddr),
    .sramWrData(sramWrData),
    .sramWrReady(sramWrReady), .seqRdReq(seqRdReq), .seqRdChan(seqRdChan),
    .seqRdGrant(seqRdGrant), .seqRdAddrValid(seqRdAddrValid), .seqRdAddr(seqRdAddr),
    .masterIrqEnable(masterIrqEnable), .fifoIrqPending(fifoIrqPending), .hostIrq(hostIrq));
  dcf_seq_model dcf_seq_model_i (
    .clk_sys(clk_sys), .rstn(rstn), .run(run), .slow(slow), .seqRdGrant(seqRdGrant),
    .seqRdAddrValid(seqRdAddrValid), .seqRdAddr(seqRdAddr), .seqRdReq(seqRdReq),
    .seqRdChan(seqRdChan), .lastAddr(lastAddr), .nReads(nReads));
  initial forever #25 clk_sys = ~clk_sys;
  // Memory write log and hang guard
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (sramWrEn === 1'b1) begin
      nWr = nWr + 1;
      lastWr = sramWrAddr;
      lastData = sramWrData;
    end
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      #1;
    end
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value %s: expected %h, seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      tick(1);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      tick(1);
      regWrEn = 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] exp, input string nm);
    begin
      tick(1);
      regAddr = a;
      regRdEn = 1'b1;
      tick(1);
      regRdEn = 1'b0;
      chk(nm, exp, regRdData);
    end
  endtask
  // Offer n samples, each held until the buffer takes it or 50 cycles pass
  task push(input integer n);
    integer i, k;
    begin
      hostWrValid = 1'b1;
      for (i = 0; i < n; i = i + 1) begin
        hostWrData = i[15:0];
        for (k = 0; k < 50 && hostWrReady !== 1'b1; k = k + 1) tick(1);
        tick(1);
      end
      hostWrValid = 1'b0;
    end
  endtask
  task wait_reads(input integer n);
    integer k;
    for (k = 0; k < 400 && nReads < n; k = k + 1) tick(1);
  endtask
  task t_reset;
    begin
      rd(12'h198, 32'h00000180, "status at reset");
      rd(12'h218, 32'h00000000, "flags at reset");
      rd(12'h21c, 32'h00000000, "irq enable at reset");
      rd(12'h300, 32'h00000000, "unmapped read");
      $display("reset test done");
    end
  endtask
  task t_fill;
    begin
      wr(12'h198, 32'h00000062);
      wr(12'h21c, 32'h00000001);
      push(16);
      chk("buffer refuses", 32'h0, hostWrReady);
      sramWrReady = 1'b1;
      tick(30);
      chk("stored samples", 32'h8, nWr);
      chk("last write address", 32'h17, lastWr);
      chk("last stored sample", 32'h7, lastData);
      rd(12'h198, 32'h00002242, "status full");
      $display("fill test done");
    end
  endtask
  task t_drain;
    begin
      wr(12'h198, 32'h80000042);
      slow = 1'b1;
      run = 1'b1;
      wait_reads(8);
      chk("last read address", 32'h17, lastAddr);
      tick(10);
      chk("reads after empty", 32'h8, nReads);
      rd(12'h198, 32'h800001c2, "status empty");
      rd(12'h218, 32'h00000001, "flag set");
      chk("host irq", 32'h1, hostIrq);
      masterIrqEnable = 1'b0;
      tick(2);
      chk("host irq masked", 32'h0, hostIrq);
      chk("irq pending", 32'h1, fifoIrqPending);
      masterIrqEnable = 1'b1;
      tick(2);
      $display("drain test done");
    end
  endtask
  task t_refill;
    begin
      run = 1'b0;
      push(4);
      tick(8);
      chk("wrapped write address", 32'h13, lastWr);
      chk("wrapped sample", 32'h3, lastData);
      rd(12'h198, 32'h80001042, "status refilled");
      rd(12'h218, 32'h00000000, "flag cleared");
      chk("host irq cleared", 32'h0, hostIrq);
      chk("pending cleared", 32'h0, fifoIrqPending);
      $display("refill test done");
    end
  endtask
  task t_replay;
    integer n0;
    begin
      wr(12'h21c, 32'h00000000);
      wr(12'h198, 32'h00000042);
      slow = 1'b0;
      run = 1'b1;
      wait_reads(20);
      chk("replay address", 32'h13, lastAddr);
      run = 1'b0;
      rd(12'h218, 32'h00000000, "flags masked");
      rd(12'h198, 32'h000001c2, "status replay");
      wr(12'h198, 32'h00000062);
      push(1);
      tick(4);
      chk("write after flush", 32'h10, lastWr);
      chk("sample after flush", 32'h0, lastData);
      rd(12'h198, 32'h00000542, "status one sample");
      wr(12'h198, 32'h00000002);
      n0 = nReads;
      run = 1'b1;
      tick(6);
      chk("reads while disabled", n0, nReads);
      chk("grant while disabled", 32'h0, seqRdGrant);
      run = 1'b0;
      $display("replay test done");
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    {regWrEn, regRdEn, hostWrValid, sramWrReady, run, slow} = 6'h00;
    masterIrqEnable = 1'b1;
    regAddr = 12'h000;
    regWrData = 32'h00000000;
    hostWrData = 16'h0000;
    {nWr, n_errors, n_checks, cyc} = 128'h0;
    repeat (4) @(posedge clk_sys);
    #1 rstn = 1'b1;
    t_reset;
    t_fill;
    t_drain;
    t_refill;
    t_replay;
    print_verdict;
  end
endmodule
